// ### design/rfb_lane.sv
// One data bit: input synchroniser and the two output copies.
// Assumes capture is aligned with the second synchroniser stage.
`timescale 1ns/1ps
module rfb_lane
(
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic d_pin,
   input  wire logic capture,
   output logic      copy_a,
   output logic      copy_b
);
   logic d_meta_ff;
   logic d_sync_ff;
   logic a_ff;
   logic b_ff;
   logic nxt_d_meta;
   logic nxt_d_sync;
   logic nxt_a;
   logic nxt_b;

   always_comb
   begin
      nxt_d_meta = d_pin;
      nxt_d_sync = d_meta_ff;
      nxt_a      = a_ff;
      nxt_b      = b_ff;
      if (capture)
      begin
         nxt_a = d_sync_ff;
         nxt_b = d_sync_ff;
      end
   end

   // Receiver stages stay cleared in reset, so floating pins never reach
   // the output registers.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         d_meta_ff <= rfb_pkg::RFB_BIT_RST;
         d_sync_ff <= rfb_pkg::RFB_BIT_RST;
         a_ff      <= rfb_pkg::RFB_BIT_RST;
         b_ff      <= rfb_pkg::RFB_BIT_RST;
      end
      else
      begin
         d_meta_ff <= nxt_d_meta;
         d_sync_ff <= nxt_d_sync;
         a_ff      <= nxt_a;
         b_ff      <= nxt_b;
      end
   end

   assign copy_a = a_ff;
   assign copy_b = b_ff;

   lane_capture_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      capture |=> (copy_a == $past(d_sync_ff)))
      else $error("A copy did not take sampled data");

   copy_match_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      copy_a == copy_b)
      else $error("A and B copies differ");

   lane_hold_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      !capture ##1 rst_n |-> $stable(copy_a) && $stable(copy_b))
      else $error("Output moved without a clock crossing");
endmodule

// ### design/rfb_pkg.sv
// Constants and carrier types of the registered fanout buffer.
// Assumes one 40 MHz system clock; clock pair and data arrive as pins.
// Notes on behaviour
// - Sample data on true rise, complement fall (code takes true rise with complement low, not its fall)
// - Thirteen registers, each with A and B copies
// - Reset low clears registers, outputs low
// - Reset low disables input receivers
package rfb_pkg;
   localparam int          RFB_WIDTH     = 13;
   localparam int          RFB_SYNC_LEN  = 2;
   localparam logic        RFB_BIT_RST   = 1'h0;
   localparam logic [12:0] RFB_WORD_RST  = 13'h0000;

   typedef struct packed {
      logic [12:0] out_copy_a;
      logic [12:0] out_copy_b;
   } rfb_out_t;
endpackage

// ### design/rfb_top.sv
// Top of the 13-bit to 26-bit registered fanout buffer.
// Assumes clk far faster than the clock pair; all pins are asynchronous.
`timescale 1ns/1ps
module rfb_top
#(
   parameter int WIDTH = rfb_pkg::RFB_WIDTH
)
(
   input  wire logic             clk,
   input  wire logic             resetn,
   input  wire logic             clk_true,
   input  wire logic             clk_comp,
   input  wire logic [WIDTH-1:0] data_in,
   output rfb_pkg::rfb_out_t     q_out
);
   // The carrier struct is fixed at the documented width
   generate
      if (WIDTH != rfb_pkg::RFB_WIDTH)
      begin : g_bad_width
         $error("WIDTH must match the output carrier width");
      end
   endgenerate

   logic rst_meta_ff;
   logic rst_sync_ff;
   logic nxt_rst_meta;
   logic nxt_rst_sync;
   logic t_meta_ff;
   logic t_sync_ff;
   logic t_prev_ff;
   logic c_meta_ff;
   logic c_sync_ff;
   logic nxt_t_meta;
   logic nxt_t_sync;
   logic nxt_t_prev;
   logic nxt_c_meta;
   logic nxt_c_sync;
   logic capture;

   always_comb
   begin
      nxt_rst_meta = 1'h1;
      nxt_rst_sync = rst_meta_ff;
   end

   // Reset asserts at once and releases through two flops
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         rst_meta_ff <= 1'h0;
         rst_sync_ff <= 1'h0;
      end
      else
      begin
         rst_meta_ff <= nxt_rst_meta;
         rst_sync_ff <= nxt_rst_sync;
      end
   end

   always_comb
   begin
      nxt_t_meta = clk_true;
      nxt_t_sync = t_meta_ff;
      nxt_t_prev = t_sync_ff;
      nxt_c_meta = clk_comp;
      nxt_c_sync = c_meta_ff;
   end

   // Clock pair receivers are held cleared in reset
   always_ff @(posedge clk or negedge rst_sync_ff)
   begin
      if (!rst_sync_ff)
      begin
         t_meta_ff <= rfb_pkg::RFB_BIT_RST;
         t_sync_ff <= rfb_pkg::RFB_BIT_RST;
         t_prev_ff <= rfb_pkg::RFB_BIT_RST;
         c_meta_ff <= rfb_pkg::RFB_BIT_RST;
         c_sync_ff <= rfb_pkg::RFB_BIT_RST;
      end
      else
      begin
         t_meta_ff <= nxt_t_meta;
         t_sync_ff <= nxt_t_sync;
         t_prev_ff <= nxt_t_prev;
         c_meta_ff <= nxt_c_meta;
         c_sync_ff <= nxt_c_sync;
      end
   end

   // Crossing: true rises while complement is already low. Checking the
   // complement level rather than its edge tolerates a sample of skew.
   assign capture = t_sync_ff & ~t_prev_ff & ~c_sync_ff;

   genvar i;
   generate
      for (i = 0; i < WIDTH; i++)
      begin : g_lane
         rfb_lane u_lane
         (
            .clk     (clk),
            .rst_n   (rst_sync_ff),
            .d_pin   (data_in[i]),
            .capture (capture),
            .copy_a  (q_out.out_copy_a[i]),
            .copy_b  (q_out.out_copy_b[i])
         );
      end
   endgenerate

   reset_low_a: assert property (
      @(posedge clk)
      !resetn && !$past(resetn) |-> (q_out == '0))
      else $error("Outputs not low during reset");

   rx_disable_a: assert property (
      @(posedge clk)
      !rst_sync_ff |-> !capture && !t_sync_ff && !c_sync_ff)
      else $error("Receivers active during reset");

   release_clean_a: assert property (
      @(posedge clk) disable iff (!resetn)
      $rose(rst_sync_ff) |-> (q_out == '0) ##1 (q_out == '0))
      else $error("Outputs not low just after reset release");

   cross_delay_a: assert property (
      @(posedge clk) disable iff (!rst_sync_ff)
      $rose(t_meta_ff) && !c_meta_ff |=> capture)
      else $error("Crossing not detected two cycles after pins");

   capture_pulse_a: assert property (
      @(posedge clk) disable iff (!rst_sync_ff)
      capture |=> !capture)
      else $error("Capture lasted more than one cycle");

   comp_block_a: assert property (
      @(posedge clk)
      c_sync_ff |-> !capture)
      else $error("Capture while complement clock high");

   edge_only_a: assert property (
      @(posedge clk)
      t_prev_ff |-> !capture)
      else $error("Capture without a true clock rise");

   level_only_a: assert property (
      @(posedge clk)
      !t_sync_ff |-> !capture)
      else $error("Capture while true clock low");

   out_hold_a: assert property (
      @(posedge clk) disable iff (!rst_sync_ff)
      !capture |=> $stable(q_out))
      else $error("Outputs moved without a crossing");

   copies_equal_a: assert property (
      @(posedge clk)
      q_out.out_copy_a == q_out.out_copy_b)
      else $error("Output copies differ");

   rst_out_low_a: assert property (
      @(posedge clk)
      !rst_sync_ff |-> (q_out == '0))
      else $error("Outputs not low under internal reset");

   meta_clear_a: assert property (
      @(posedge clk)
      !rst_sync_ff |-> !t_meta_ff && !c_meta_ff && !t_prev_ff)
      else $error("Clock pair front stage active in reset");

   prev_follow_a: assert property (
      @(posedge clk) disable iff (!rst_sync_ff)
      t_prev_ff == $past(t_sync_ff))
      else $error("Edge detector lost its previous sample");

   true_follow_a: assert property (
      @(posedge clk) disable iff (!rst_sync_ff)
      t_sync_ff == $past(t_meta_ff))
      else $error("True clock synchroniser skipped a stage");

   comp_follow_a: assert property (
      @(posedge clk) disable iff (!rst_sync_ff)
      c_sync_ff == $past(c_meta_ff))
      else $error("Complement synchroniser skipped a stage");

   rst_follow_a: assert property (
      @(posedge clk) disable iff (!resetn)
      rst_sync_ff == $past(rst_meta_ff))
      else $error("Reset release skipped a stage");

   rst_meta_a: assert property (
      @(posedge clk) disable iff (!resetn)
      $past(resetn) |-> rst_meta_ff)
      else $error("Reset release first stage stuck low");

   release_two_a: assert property (
      @(posedge clk) disable iff (!resetn)
      !$past(rst_meta_ff) |-> !rst_sync_ff)
      else $error("Reset released in fewer than two edges");

   // Per-bit checks name the failing lane in the hierarchy
   genvar j;
   generate
      for (j = 0; j < WIDTH; j++)
      begin : g_bit_chk
         bit_pair_a: assert property (
            @(posedge clk)
            q_out.out_copy_a[j] == q_out.out_copy_b[j])
            else $error("Copy bits differ");

         bit_hold_a: assert property (
            @(posedge clk) disable iff (!rst_sync_ff)
            !capture |=> $stable(q_out.out_copy_a[j]))
            else $error("Output bit moved without a crossing");

         bit_low_a: assert property (
            @(posedge clk)
            !rst_sync_ff |-> !q_out.out_copy_a[j] && !q_out.out_copy_b[j])
            else $error("Output bit not low in reset");
      end
   endgenerate
endmodule

// ### dv/registered_fanout_buffer_bench.sv
// Bench for rfb_top with the controller model on the pins.
// Assumes the 40 MHz clock and the three-edge answer latency.
`timescale 1ns/1ps
module registered_fanout_buffer_bench;
   logic              clk;
   logic              resetn;
   logic              go;
   logic              no_fall;
   logic [12:0]       word;
   logic [12:0]       data_in;
   logic              clk_true;
   logic              clk_comp;
   rfb_pkg::rfb_out_t q_out;
   int                bad_count;
   int                num_checks;
   rfb_top #(.WIDTH(13)) uut (.clk(clk), .resetn(resetn),
      .clk_true(clk_true), .clk_comp(clk_comp), .data_in(data_in),
      .q_out(q_out));
   rfb_ctrl_model ctrl (.clk(clk), .go(go), .no_fall(no_fall),
      .word(word), .clk_true(clk_true), .clk_comp(clk_comp),
      .data_in(data_in));
   initial
   begin
      clk = 1'h0;
      forever #12.5 clk = ~clk;
   end
   task automatic check(input string nm, input logic [12:0] exp);
      num_checks++;
      if (q_out.out_copy_a !== exp || q_out.out_copy_b !== exp)
      begin
         bad_count++;
         $display("ERROR %s expected %h seen %h %h", nm, exp,
            q_out.out_copy_a, q_out.out_copy_b);
      end
   endtask
   task automatic send(input logic [12:0] w, input logic nf);
      @(posedge clk);
      go      <= 1'h1;
      word    <= w;
      no_fall <= nf;
      @(posedge clk);
      go <= 1'h0;
      repeat (10) @(posedge clk);
   endtask
   task automatic complete_run;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic t_xfer;
      send(13'h1555, 1'h0);
      check("xfer_a", 13'h1555);
      send(13'h0AAA, 1'h0);
      check("xfer_b", 13'h0AAA);
      $display("t_xfer done");
   endtask
   task automatic t_nofall;
      send(13'h1FFF, 1'h0);
      send(13'h0123, 1'h1);
      check("nofall", 13'h1FFF);
      $display("t_nofall done");
   endtask
   task automatic t_reset;
      @(posedge clk);
      resetn <= 1'h0;
      #1 check("rst_now", 13'h0000);
      send(13'h1FFF, 1'h0);
      check("rst_held", 13'h0000);
      @(posedge clk);
      resetn <= 1'h1;
      repeat (3) @(posedge clk);
      check("rst_after", 13'h0000);
      send(13'h0F0F, 1'h0);
      check("rst_resume", 13'h0F0F);
      $display("t_reset done");
   endtask
   initial
   begin
      bad_count  = 0;
      num_checks = 0;
      resetn     = 1'h0;
      go         = 1'h0;
      no_fall    = 1'h0;
      word       = 13'h0000;
      repeat (12) @(posedge clk);
      resetn <= 1'h1;
      repeat (3) @(posedge clk);
      t_xfer();
      t_nofall();
      t_reset();
      complete_run();
   end
   initial
   begin
      repeat (1000) @(posedge clk);
      bad_count++;
      complete_run();
   end
endmodule

// ### dv/rfb_ctrl_model.sv
// Controller model: drives the clock pair and data for one transfer.
// Assumes go is a one-cycle pulse from the bench.
`timescale 1ns/1ps
module rfb_ctrl_model
(
   input  wire logic        clk,
   input  wire logic        go,
   input  wire logic        no_fall,
   input  wire logic [12:0] word,
   output logic             clk_true,
   output logic             clk_comp,
   output logic [12:0]      data_in
);
   logic [3:0] cnt_ff;
   initial
   begin
      cnt_ff   = 4'h0;
      clk_true = 1'h0;
      clk_comp = 1'h1;
      data_in  = 13'h0000;
   end
   always @(posedge clk)
   begin
      if (go && cnt_ff == 4'h0)
      begin
         data_in <= word;
         cnt_ff  <= 4'h8;
      end
      else if (cnt_ff != 4'h0)
         cnt_ff <= cnt_ff - 4'h1;
      if (cnt_ff == 4'h7)
      begin
         clk_true <= 1'h1;
         clk_comp <= no_fall;
      end
      if (cnt_ff == 4'h3)
      begin
         clk_true <= 1'h0;
         clk_comp <= 1'h1;
      end
      // Hold time over: show the inverse, not a stale word
      if (cnt_ff == 4'h1)
         data_in <= ~data_in;
   end
endmodule
